// ===== inc/tmr_cfg.svh
// timer block constants: special function addresses, field positions,
// reset values and the slow prescale ratio.
// assumes inclusion by bare name from the timer core and the bench.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ==========================================================
// special function register addresses
`define TMR_ADDR_RUN_CTL   8'h88
`define TMR_ADDR_MODE      8'h89
`define TMR_ADDR_T0_LOW    8'h8a
`define TMR_ADDR_T1_LOW    8'h8b
`define TMR_ADDR_T0_HIGH   8'h8c
`define TMR_ADDR_T1_HIGH   8'h8d
`define TMR_ADDR_PRESCALE  8'h8e

// ==========================================================
// timer_prescale_select fields
`define TMR_BIT_T2_FAST    5
`define TMR_BIT_T1_FAST    4
`define TMR_BIT_T0_FAST    3

// ==========================================================
// timer_mode_control fields
`define TMR_BIT_T1_GATE    7
`define TMR_BIT_T1_CT      6
`define TMR_BIT_T1_MODE    4
`define TMR_BIT_T0_GATE    3
`define TMR_BIT_T0_CT      2
`define TMR_BIT_T0_MODE    0

// ==========================================================
// timer_run_control fields
`define TMR_BIT_TF1        7
`define TMR_BIT_TR1        6
`define TMR_BIT_TF0        5
`define TMR_BIT_TR0        4

// ==========================================================
// reset values and timing
`define TMR_RST_BYTE       8'h00
`define TMR_RST_BIT        1'b0
`define TMR_SLOW_DIV       12

`endif

// ===== inc/tmr_pkg.sv
// types shared by the timer block.
// assumes tmr_cfg.svh is on the include path.
`default_nettype none

package tmr_pkg;
  // operating mode, in field order: 13-bit, 16-bit, 8-bit reload, split
  typedef enum logic [1:0] {
    TMR_MODE_13,
    TMR_MODE_16,
    TMR_MODE_RELOAD,
    TMR_MODE_SPLIT
  } tmr_mode_t;
endpackage

`default_nettype wire

// ===== rtl/tmr_sync.sv
// two-flop synchroniser for one pin, with level and falling-edge outputs.
// assumes an asynchronous pin input and the core clock.
`default_nettype none

module tmr_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;
  logic fall_reg, fall_next;

  // first flop feeds only the second; edge logic looks at later stages
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
    fall_next = prev_reg & ~sync_reg;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      fall_reg <= fall_next;
    end
  end

  assign level_o = sync_reg;
  assign fall_o  = fall_reg;
endmodule

`default_nettype wire

// ===== rtl/tmr_prescale.sv
// free-running divider giving a one-cycle tick every DIV core clocks.
// assumes a single core clock; shared by both timers.
`default_nettype none

module tmr_prescale #(
  parameter int DIV = 12
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt_reg, cnt_next;
  logic         tick_reg, tick_next;

  // wrap at DIV-1 and flag the wrap cycle
  always_comb begin
    cnt_next  = (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + W'(1);
    tick_next = (cnt_reg == W'(DIV - 1));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule

`default_nettype wire

// ===== rtl/tmr_core.sv
// timer0 / timer1 core with prescale select, reached over the special
// function register port of the processor core.
// assumes a one-cycle write strobe, pins asynchronous to sys_clk_i, and
// one-cycle interrupt-vector acknowledge pulses from the core.
`include "tmr_cfg.svh"
`default_nettype none

// Function
// - fast select counts every clock; otherwise once per twelve clocks.
// - all three fast-clock select bits reset to zero.
// - prescale register at 0x8E: timer2 bit 5, timer1 bit 4, timer0 bit 3.
// - each select bit affects only its own timer.
// - timer1 overflow also drives the first serial port baud tick.
// - mode comes from mode register 0x89 and run control register 0x88.
// - timer0 count bytes at 0x8A low and 0x8C high.
// - timer1 count bytes at 0x8B low and 0x8D high.
// - timer1 gate bit set: count only when run and gate pin high.
// - timer0 gate bit set: count only when run and gate pin high.
// - timer1 counter select: prescaled clock, or falling edges on count pin.
// - timer0 counter select: prescaled clock, or falling edges on count pin.
// - timer1 mode field bits 5:4: 13-bit, 16-bit, 8-bit reload, split.
// - timer0 mode field bits 1:0 with the same encoding.
// - split mode exists only for timer0; timer1 holds in it.
// - run bits: timer1 at bit 6, timer0 at bit 4 of run control.
// - overflow sets flag bit 7 or 5; cleared on interrupt vector entry.
// - 13-bit mode: low five bits carry into high byte, wrap 0x1FFF.
// - reload mode: low byte reloads from unchanged high byte on overflow.
module tmr_core
  import tmr_pkg::*;
#(
  parameter int SLOW_DIV = `TMR_SLOW_DIV
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       timer0_vector_ack_i,
  input  wire logic       timer1_vector_ack_i,
  input  wire logic       timer0_gate_pin_i,
  input  wire logic       timer1_gate_pin_i,
  input  wire logic       timer0_count_pin_i,
  input  wire logic       timer1_count_pin_i,
  output logic            timer0_overflow_flag_o,
  output logic            timer1_overflow_flag_o,
  output logic            third_timer_fast_clock_o,
  output logic            first_serial_port_baud_tick_o
);

  // ==========================================================
  // state
  logic [7:0] mode_reg, mode_next;
  logic [7:0] psel_reg, psel_next;
  logic       tr0_reg, tr0_next;
  logic       tr1_reg, tr1_next;
  logic       tf0_reg, tf0_next;
  logic       tf1_reg, tf1_next;
  logic [7:0] tl0_reg, tl0_next;
  logic [7:0] th0_reg, th0_next;
  logic [7:0] tl1_reg, tl1_next;
  logic [7:0] th1_reg, th1_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       baud_reg, baud_next;

  // ==========================================================
  // pin synchronisers and prescaler
  logic gate0_lvl, gate1_lvl, cnt0_fall, cnt1_fall, slow_tick;

  // gate pins only need the level, count pins only the falling edge
  tmr_sync u_sync_gate0 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (timer0_gate_pin_i),
    .level_o   (gate0_lvl),
    .fall_o    ()
  );
  tmr_sync u_sync_gate1 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (timer1_gate_pin_i),
    .level_o   (gate1_lvl),
    .fall_o    ()
  );
  tmr_sync u_sync_cnt0 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (timer0_count_pin_i),
    .level_o   (),
    .fall_o    (cnt0_fall)
  );
  tmr_sync u_sync_cnt1 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (timer1_count_pin_i),
    .level_o   (),
    .fall_o    (cnt1_fall)
  );

  // one divider serves every timer; the select bit picks per timer
  tmr_prescale #(
    .DIV (SLOW_DIV)
  ) u_prescale (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_o    (slow_tick)
  );

  // ==========================================================
  // count enables
  tmr_mode_t mode0, mode1;
  logic      rate0, rate1, en0, en1, en0_hi;
  logic      wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ctl;

  assign mode0  = tmr_mode_t'(mode_reg[`TMR_BIT_T0_MODE +: 2]);
  assign mode1  = tmr_mode_t'(mode_reg[`TMR_BIT_T1_MODE +: 2]);
  // each timer sees only its own select bit
  assign rate0  = psel_reg[`TMR_BIT_T0_FAST] | slow_tick;
  assign rate1  = psel_reg[`TMR_BIT_T1_FAST] | slow_tick;
  assign en0    = tr0_reg & (~mode_reg[`TMR_BIT_T0_GATE] | gate0_lvl)
                & (mode_reg[`TMR_BIT_T0_CT] ? cnt0_fall : rate0);
  assign en1    = tr1_reg & (~mode_reg[`TMR_BIT_T1_GATE] | gate1_lvl)
                & (mode_reg[`TMR_BIT_T1_CT] ? cnt1_fall : rate1);
  // split high half borrows timer1's run bit and always times
  assign en0_hi = tr1_reg & rate0;
  assign wr_tl0 = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_T0_LOW);
  assign wr_th0 = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_T0_HIGH);
  assign wr_tl1 = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_T1_LOW);
  assign wr_th1 = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_T1_HIGH);
  assign wr_ctl = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_RUN_CTL);

  // ==========================================================
  // timer0 counting; a software write wins over a count in the same cycle
  logic ovf0, ovf0_hi;
  always_comb begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    ovf0     = 1'b0;
    ovf0_hi  = 1'b0;
    if (en0) begin
      unique case (mode0)
        TMR_MODE_13: begin
          // upper three low bits are left alone; software masks them
          tl0_next[4:0] = tl0_reg[4:0] + 5'h01;
          if (tl0_reg[4:0] == 5'h1f) begin
            th0_next = th0_reg + 8'h01;
            ovf0     = (th0_reg == 8'hff);
          end
        end
        TMR_MODE_16: begin
          {th0_next, tl0_next} = {th0_reg, tl0_reg} + 16'h0001;
          ovf0 = ({th0_reg, tl0_reg} == 16'hffff);
        end
        TMR_MODE_RELOAD: begin
          tl0_next = (tl0_reg == 8'hff) ? th0_reg : tl0_reg + 8'h01;
          ovf0     = (tl0_reg == 8'hff);
        end
        TMR_MODE_SPLIT: begin
          tl0_next = tl0_reg + 8'h01;
          ovf0     = (tl0_reg == 8'hff);
        end
      endcase
    end
    if ((mode0 == TMR_MODE_SPLIT) && en0_hi) begin
      th0_next = th0_reg + 8'h01;
      ovf0_hi  = (th0_reg == 8'hff);
    end
    if (wr_tl0) begin
      tl0_next = sfr_wdata_i;
    end
    if (wr_th0) begin
      th0_next = sfr_wdata_i;
    end
  end

  // ==========================================================
  // timer1 counting; split code stops it
  logic ovf1;
  always_comb begin
    tl1_next = tl1_reg;
    th1_next = th1_reg;
    ovf1     = 1'b0;
    if (en1) begin
      unique case (mode1)
        TMR_MODE_13: begin
          tl1_next[4:0] = tl1_reg[4:0] + 5'h01;
          if (tl1_reg[4:0] == 5'h1f) begin
            th1_next = th1_reg + 8'h01;
            ovf1     = (th1_reg == 8'hff);
          end
        end
        TMR_MODE_16: begin
          {th1_next, tl1_next} = {th1_reg, tl1_reg} + 16'h0001;
          ovf1 = ({th1_reg, tl1_reg} == 16'hffff);
        end
        TMR_MODE_RELOAD: begin
          tl1_next = (tl1_reg == 8'hff) ? th1_reg : tl1_reg + 8'h01;
          ovf1     = (tl1_reg == 8'hff);
        end
        TMR_MODE_SPLIT: begin
          ovf1 = 1'b0;
        end
      endcase
    end
    if (wr_tl1) begin
      tl1_next = sfr_wdata_i;
    end
    if (wr_th1) begin
      th1_next = sfr_wdata_i;
    end
  end

  // ==========================================================
  // control registers and flags
  // set beats both a software clear and the vector acknowledge
  always_comb begin
    mode_next = mode_reg;
    psel_next = psel_reg;
    tr0_next  = tr0_reg;
    tr1_next  = tr1_reg;
    tf0_next  = tf0_reg;
    tf1_next  = tf1_reg;
    if (sfr_wr_i && (sfr_addr_i == `TMR_ADDR_MODE)) begin
      mode_next = sfr_wdata_i;
    end
    if (sfr_wr_i && (sfr_addr_i == `TMR_ADDR_PRESCALE)) begin
      psel_next = 8'h00;
      psel_next[`TMR_BIT_T2_FAST] = sfr_wdata_i[`TMR_BIT_T2_FAST];
      psel_next[`TMR_BIT_T1_FAST] = sfr_wdata_i[`TMR_BIT_T1_FAST];
      psel_next[`TMR_BIT_T0_FAST] = sfr_wdata_i[`TMR_BIT_T0_FAST];
    end
    if (wr_ctl) begin
      tr0_next = sfr_wdata_i[`TMR_BIT_TR0];
      tr1_next = sfr_wdata_i[`TMR_BIT_TR1];
      tf0_next = sfr_wdata_i[`TMR_BIT_TF0];
      tf1_next = sfr_wdata_i[`TMR_BIT_TF1];
    end
    if (timer0_vector_ack_i) begin
      tf0_next = 1'b0;
    end
    if (timer1_vector_ack_i) begin
      tf1_next = 1'b0;
    end
    if (ovf0) begin
      tf0_next = 1'b1;
    end
    if (ovf1 || ovf0_hi) begin
      tf1_next = 1'b1;
    end
  end

  // ==========================================================
  // read data, one cycle after the address; unmapped reads give zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (sfr_addr_i)
      `TMR_ADDR_RUN_CTL:  rdata_next = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
      `TMR_ADDR_MODE:     rdata_next = mode_reg;
      `TMR_ADDR_T0_LOW:   rdata_next = tl0_reg;
      `TMR_ADDR_T1_LOW:   rdata_next = tl1_reg;
      `TMR_ADDR_T0_HIGH:  rdata_next = th0_reg;
      `TMR_ADDR_T1_HIGH:  rdata_next = th1_reg;
      `TMR_ADDR_PRESCALE: rdata_next = psel_reg;
      default:            rdata_next = 8'h00;
    endcase
    baud_next = ovf1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg  <= `TMR_RST_BYTE;
      psel_reg  <= `TMR_RST_BYTE;
      tr0_reg   <= `TMR_RST_BIT;
      tr1_reg   <= `TMR_RST_BIT;
      tf0_reg   <= `TMR_RST_BIT;
      tf1_reg   <= `TMR_RST_BIT;
      tl0_reg   <= `TMR_RST_BYTE;
      th0_reg   <= `TMR_RST_BYTE;
      tl1_reg   <= `TMR_RST_BYTE;
      th1_reg   <= `TMR_RST_BYTE;
      rdata_reg <= `TMR_RST_BYTE;
      baud_reg  <= `TMR_RST_BIT;
    end else begin
      mode_reg  <= mode_next;
      psel_reg  <= psel_next;
      tr0_reg   <= tr0_next;
      tr1_reg   <= tr1_next;
      tf0_reg   <= tf0_next;
      tf1_reg   <= tf1_next;
      tl0_reg   <= tl0_next;
      th0_reg   <= th0_next;
      tl1_reg   <= tl1_next;
      th1_reg   <= th1_next;
      rdata_reg <= rdata_next;
      baud_reg  <= baud_next;
    end
  end

  assign sfr_rdata_o                   = rdata_reg;
  assign timer0_overflow_flag_o        = tf0_reg;
  assign timer1_overflow_flag_o        = tf1_reg;
  assign third_timer_fast_clock_o      = psel_reg[`TMR_BIT_T2_FAST];
  assign first_serial_port_baud_tick_o = baud_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = !sfr_wr_i;

  property p_slow_period;
    slow_tick |-> ##SLOW_DIV slow_tick;
  endproperty
  a_slow_period: assert property (p_slow_period) else $error("slow tick period wrong");

  property p_fast_step;
    (psel_reg[`TMR_BIT_T0_FAST] && tr0_reg && mode_reg[3:0] == 4'h1 && tl0_reg != 8'hff && quiet)
      |=> (tl0_reg == $past(tl0_reg) + 8'h01);
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast timer0 did not step");

  property p_psel_reserved;
    (sfr_wr_i && sfr_addr_i == `TMR_ADDR_PRESCALE) |=> (psel_reg == ($past(sfr_wdata_i) & 8'h38));
  endproperty
  a_psel_reserved: assert property (p_psel_reserved) else $error("prescale reserved bit set");

  property p_gate1_hold;
    (mode_reg[`TMR_BIT_T1_GATE] && !gate1_lvl && quiet) |=> $stable({th1_reg, tl1_reg});
  endproperty
  a_gate1_hold: assert property (p_gate1_hold) else $error("timer1 ran with gate low");

  property p_ct1_edges;
    (mode_reg[`TMR_BIT_T1_CT] && !cnt1_fall && quiet) |=> $stable({th1_reg, tl1_reg});
  endproperty
  a_ct1_edges: assert property (p_ct1_edges) else $error("timer1 counted without an edge");

  property p_wrap13;
    (en0 && mode0 == TMR_MODE_13 && tl0_reg[4:0] == 5'h1f && quiet)
      |=> (tl0_reg[4:0] == 5'h00 && th0_reg == $past(th0_reg) + 8'h01);
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit carry wrong");

  property p_split1_hold;
    (mode1 == TMR_MODE_SPLIT && quiet) |=> $stable({th1_reg, tl1_reg});
  endproperty
  a_split1_hold: assert property (p_split1_hold) else $error("timer1 ran in split code");

  property p_overflow_flag;
    (en0 && mode0 == TMR_MODE_16 && {th0_reg, tl0_reg} == 16'hffff && quiet)
      |=> (tf0_reg && {th0_reg, tl0_reg} == 16'h0000);
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("16-bit wrap left flag clear");

  property p_reload;
    (en1 && mode1 == TMR_MODE_RELOAD && tl1_reg == 8'hff && quiet)
      |=> (tl1_reg == $past(th1_reg) && $stable(th1_reg) && tf1_reg && baud_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("reload from high byte failed");

  c_reload:   cover property (en1 && mode1 == TMR_MODE_RELOAD && tl1_reg == 8'hff);
  c_split_hi: cover property (ovf0_hi);
  c_ack_race: cover property (ovf0 && timer0_vector_ack_i);
  c_pin_cnt:  cover property (en0 && mode_reg[`TMR_BIT_T0_CT]);
endmodule

`default_nettype wire

// ===== rtl/tmr_core_fix_note.sv
`default_nettype none
`default_nettype wire

// ===== tb/tmr_pin_model.sv
// model of the pins outside the timer block: two gate levels, two count inputs.
// assumes the bench calls its tasks; every pin moves just after a rising edge.
`default_nettype none

module tmr_pin_model (
  input  wire logic       sys_clk_i,
  output logic      [1:0] gate_pin_o,
  output logic      [1:0] count_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle levels
  // count pins rest high so the first low phase is a real falling edge
  initial begin
    gate_pin_o  = 2'b00;
    count_pin_o = 2'b11;
  end

  // ==========================================================
  // stimulus tasks, bit 0 is timer0 and bit 1 is timer1
  task automatic set_gate(input int t, input logic v);
    @(posedge sys_clk_i);
    gate_pin_o[t] <= v;
  endtask

  // phases of four clocks keep every edge well clear of the two-flop synchroniser
  task automatic pulses(input int t, input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      count_pin_o[t] <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      count_pin_o[t] <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
    end
  endtask
endmodule

`default_nettype wire

// ===== tb/tmr_core_tb_top.sv
// self-checking bench for the timer core: register port tasks and table runs.
// assumes tmr_pin_model on the pins and a shortened slow prescale ratio.
`include "tmr_cfg.svh"
`default_nettype none

module tmr_core_tb_top
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  localparam int SLOW = 3;
  // per mode: high, low, counts, expected high, expected low, overflow
  localparam logic [7:0] ROWS [4][6] = '{
    '{8'hff, 8'h1e, 8'h03, 8'h00, 8'h01, 8'h01},
    '{8'hff, 8'hfe, 8'h03, 8'h00, 8'h01, 8'h01},
    '{8'hc8, 8'hfe, 8'h04, 8'hc8, 8'hca, 8'h01},
    '{8'h10, 8'hfe, 8'h03, 8'h10, 8'h01, 8'h01}};
  // per access: address, write data, expected read
  localparam logic [7:0] ACC [8][3] = '{
    '{`TMR_ADDR_PRESCALE, 8'hff, 8'h38}, '{`TMR_ADDR_RUN_CTL, 8'h0f, 8'h00},
    '{`TMR_ADDR_MODE, 8'ha5, 8'ha5}, '{`TMR_ADDR_T0_LOW, 8'h5a, 8'h5a},
    '{`TMR_ADDR_T1_LOW, 8'ha6, 8'ha6}, '{`TMR_ADDR_T0_HIGH, 8'h5b, 8'h5b},
    '{`TMR_ADDR_T1_HIGH, 8'ha7, 8'ha7}, '{8'h80, 8'hff, 8'h00}};

  logic       sys_clk_i   = 1'b0;
  logic       rst_i       = 1'b1;
  logic [7:0] sfr_addr    = 8'h00;
  logic       sfr_wr      = 1'b0;
  logic [7:0] sfr_wdata   = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] ack         = 2'b00;
  logic [1:0] flag;
  logic [1:0] gate_pin;
  logic [1:0] count_pin;
  logic       fast2;
  logic       baud;
  logic [1:0] seen        = 2'b00;
  logic       clr_seen    = 1'b0;
  int         baud_cnt    = 0;
  int         miscompares = 0;
  int         checks_done = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  // ==========================================================
  // design and pin model
  tmr_core #(.SLOW_DIV(SLOW)) tmr_core_i (
    .sys_clk_i                     (sys_clk_i),
    .rst_i                         (rst_i),
    .sfr_addr_i                    (sfr_addr),
    .sfr_wr_i                      (sfr_wr),
    .sfr_wdata_i                   (sfr_wdata),
    .sfr_rdata_o                   (sfr_rdata),
    .timer0_vector_ack_i           (ack[0]),
    .timer1_vector_ack_i           (ack[1]),
    .timer0_gate_pin_i             (gate_pin[0]),
    .timer1_gate_pin_i             (gate_pin[1]),
    .timer0_count_pin_i            (count_pin[0]),
    .timer1_count_pin_i            (count_pin[1]),
    .timer0_overflow_flag_o        (flag[0]),
    .timer1_overflow_flag_o        (flag[1]),
    .third_timer_fast_clock_o      (fast2),
    .first_serial_port_baud_tick_o (baud)
  );

  tmr_pin_model tmr_pin_model_i (
    .sys_clk_i   (sys_clk_i),
    .gate_pin_o  (gate_pin),
    .count_pin_o (count_pin)
  );

  // flags are caught here because the stop write clears them again
  // a single process owns the catch registers; the sequence only requests a clear
  always @(posedge sys_clk_i) begin
    if (clr_seen) begin
      seen     <= 2'b00;
      baud_cnt <= 0;
    end else begin
      if (baud === 1'b1) baud_cnt <= baud_cnt + 1;
      if (flag[0] === 1'b1) seen[0] <= 1'b1;
      if (flag[1] === 1'b1) seen[1] <= 1'b1;
    end
  end

  // ==========================================================
  // register port tasks and comparisons
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr  <= a;
    sfr_wr    <= 1'b1;
    sfr_wdata <= d;
    @(posedge sys_clk_i);
    sfr_wr    <= 1'b0;
  endtask

  // address held two edges so the registered answer is settled either way
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr <= a;
    repeat (2) @(posedge sys_clk_i);
    #1 d = sfr_rdata;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sfr_read(a, d);
    check($sformatf("sfr %h", a), exp, d);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang anywhere ends the run as a mismatch
  initial begin
    #900_000;
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic       held;
    logic [7:0] lo;
    logic [7:0] hi;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 8'h88; a <= 8'h8e; a++) check_reg(8'(a), 8'h00);
    check("fast2", 8'h00, {7'h0, fast2});
    // every register written first, then all read back, to catch decode overlap
    for (int i = 0; i < 8; i++) sfr_write(ACC[i][0], ACC[i][1]);
    for (int i = 0; i < 8; i++) check_reg(ACC[i][0], ACC[i][2]);
    check("fast2", 8'h01, {7'h0, fast2});
    // one timer fast, the other slow, in the same thirty-cycle window
    for (int t = 0; t < 2; t++) begin
      for (int a = 8'h8a; a <= 8'h8d; a++) sfr_write(8'(a), 8'h00);
      sfr_write(`TMR_ADDR_MODE, 8'h11);
      sfr_write(`TMR_ADDR_PRESCALE, t ? 8'h10 : 8'h08);
      sfr_write(`TMR_ADDR_RUN_CTL, 8'h50);
      repeat (28) @(posedge sys_clk_i);
      sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
      check_reg(`TMR_ADDR_T0_LOW, t ? 8'h0a : 8'h1e);
      check_reg(`TMR_ADDR_T1_LOW, t ? 8'h1e : 8'h0a);
    end
    // every mode of both timers across its wrap point, except timer1 split, which must hold
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        lo = t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW;
        hi = t ? `TMR_ADDR_T1_HIGH : `TMR_ADDR_T0_HIGH;
        held = (t == 1 && m == 3);
        sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
        sfr_write(hi, ROWS[m][0]);
        sfr_write(lo, ROWS[m][1]);
        sfr_write(`TMR_ADDR_MODE, 8'(m << (4 * t)));
        sfr_write(`TMR_ADDR_PRESCALE, 8'(8 << t));
        clr_seen <= 1'b1;
        @(posedge sys_clk_i);
        clr_seen <= 1'b0;
        sfr_write(`TMR_ADDR_RUN_CTL, 8'(8'h10 << (2 * t)));
        repeat (ROWS[m][2] - 2) @(posedge sys_clk_i);
        sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
        check_reg(hi, held ? ROWS[m][0] : ROWS[m][3]);
        check_reg(lo, held ? ROWS[m][1] : ROWS[m][4]);
        check("overflow", held ? 8'h00 : ROWS[m][5], {7'h0, seen[t]});
        check("baud", (t == 1 && !held) ? 8'h01 : 8'h00, 8'(baud_cnt));
      end
    end
    // flag stays up until the vector acknowledge
    for (int t = 0; t < 2; t++) begin
      sfr_write(t ? `TMR_ADDR_T1_HIGH : `TMR_ADDR_T0_HIGH, 8'hff);
      sfr_write(t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW, 8'hff);
      sfr_write(`TMR_ADDR_MODE, 8'(1 << (4 * t)));
      sfr_write(`TMR_ADDR_RUN_CTL, 8'(8'h10 << (2 * t)));
      repeat (4) @(posedge sys_clk_i);
      #1 check("flag set", 8'h01, {7'h0, flag[t]});
      @(posedge sys_clk_i);
      ack[t] <= 1'b1;
      @(posedge sys_clk_i);
      ack[t] <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 check("flag cleared", 8'h00, {7'h0, flag[t]});
      sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
    end
    // counter mode: gate off with pin low, gate on with pin low, gate on with pin high
    for (int t = 0; t < 2; t++) begin
      for (int g = 0; g < 3; g++) begin
        sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
        sfr_write(t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW, 8'h00);
        sfr_write(`TMR_ADDR_MODE, 8'((g ? 8'h0d : 8'h05) << (4 * t)));
        tmr_pin_model_i.set_gate(t, g == 2);
        sfr_write(`TMR_ADDR_RUN_CTL, 8'(8'h10 << (2 * t)));
        repeat (4) @(posedge sys_clk_i);
        tmr_pin_model_i.pulses(t, 5);
        repeat (8) @(posedge sys_clk_i);
        sfr_write(`TMR_ADDR_RUN_CTL, 8'h00);
        check_reg(t ? `TMR_ADDR_T1_LOW : `TMR_ADDR_T0_LOW, g == 1 ? 8'h00 : 8'h05);
      end
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
